// *** core/hrsp_pkg.sv ***
// constants, codes and types for the home-return and serial positioning block
package hrsp_pkg;
    // clock and stopper-time unit
    localparam int CLK_HZ = 50_000_000;
    localparam int STOP_UNIT_US = 1000;
    localparam int CYC_PER_UNIT = CLK_HZ / 1_000_000 * STOP_UNIT_US;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_HOME_SPEED = 12'h004;
    localparam logic [11:0] OFS_STOP_TIME = 12'h008;
    localparam logic [11:0] OFS_STOP_TORQUE = 12'h00c;
    localparam logic [11:0] OFS_HOME_DATA = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h018;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h01c;
    // control fields
    localparam int CTRL_METH_LSB = 0;
    localparam int CTRL_DIR = 3;
    localparam int CTRL_SOFTLIM = 4;
    localparam int CTRL_PORT = 5;
    localparam int CTRL_LINK_EN = 6;
    localparam int CTRL_STN_LSB = 8;
    localparam int CTRL_W = 13;
    // status fields
    localparam int STAT_DONE = 0;
    localparam int STAT_ALARM = 1;
    localparam int STAT_MOVE = 2;
    localparam int STAT_STATE_LSB = 4;
    // interrupt bits
    localparam int IRQ_HOME = 0;
    localparam int IRQ_ALARM = 1;
    localparam int IRQ_POSN = 2;
    localparam int IRQ_W = 3;
    // reset values
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [15:0] TRQ_FULL = 16'hffff;
    // home-return method codes
    localparam logic [2:0] METH_DOG = 3'h0;
    localparam logic [2:0] METH_COUNT = 3'h1;
    localparam logic [2:0] METH_DATA = 3'h2;
    localparam logic [2:0] METH_STOP = 3'h3;
    localparam logic [2:0] METH_IGNORE = 3'h4;
    // serial commands and data numbers
    localparam logic [7:0] CMD_FORCE = 8'h92;
    localparam logic [7:0] DNO_FORCE = 8'h60;
    localparam logic [7:0] CMD_POS = 8'hc0;
    localparam logic [7:0] CMD_SPD = 8'hc6;
    localparam logic [7:0] CMD_ACC = 8'hc7;
    localparam logic [7:0] CMD_DEC = 8'hc8;
    localparam logic [7:0] CMD_AUX = 8'hcb;
    localparam int NUM_TABLES = 15;
    // forced-output data bits
    localparam int FRC_FWD = 4;
    localparam int FRC_REV = 5;
    localparam int FRC_MD = 6;
    // synchronised pin order
    localparam int PIN_MD = 0;
    localparam int PIN_SEL0 = 1;
    localparam int PIN_SEL1 = 2;
    localparam int PIN_FWD = 3;
    localparam int PIN_REV = 4;
    localparam int PIN_SRV = 5;
    localparam int PIN_DOG = 6;
    localparam int PIN_LSP = 7;
    localparam int PIN_LSN = 8;
    localparam int NUM_PINS = 9;

    typedef enum logic [2:0] {
        ST_IDLE, ST_STOP_SEEK, ST_STOP_DWELL, ST_AUTO_SEEK, ST_AUTO_BACK, ST_POSN
    } hrsp_state_e;

    typedef struct packed {
        logic [31:0] pos;
        logic [15:0] spd;
        logic [15:0] acc;
        logic [15:0] dec;
        logic [3:0] aux;
    } hrsp_entry_s;
endpackage : hrsp_pkg

// *** core/hrsp_top.sv ***
// home-return sequencer, serial command decoder and point-table positioning
`timescale 1ns/1ns
`default_nettype none
module hrsp_top
    import hrsp_pkg::*;
#(
    parameter int P_CYC_PER_MS = CYC_PER_UNIT
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_SYS_RST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_IRQ,
    // asynchronous pins
    input wire logic I_AUTO_MANUAL_SELECT,
    input wire logic I_TABLE_SELECT_BIT0,
    input wire logic I_TABLE_SELECT_BIT1,
    input wire logic I_FORWARD_START,
    input wire logic I_REVERSE_START,
    input wire logic I_SERVO_ON,
    input wire logic I_DOG,
    input wire logic I_LIMIT_FWD,
    input wire logic I_LIMIT_REV,
    // motion core feedback
    input wire logic [31:0] I_POSITION,
    input wire logic I_TORQUE_AT_LIMIT,
    input wire logic I_IN_POSITION,
    // decoded serial frames
    input wire logic I_FRM_VALID,
    input wire logic I_FRM_PORT,
    input wire logic [4:0] I_FRM_STATION,
    input wire logic [7:0] I_FRM_CMD,
    input wire logic [7:0] I_FRM_DNO,
    input wire logic [31:0] I_FRM_DATA,
    output logic O_REPLY_VALID,
    // motion commands
    output logic O_MOVE_ACTIVE,
    output logic O_MOVE_DIR,
    output logic [15:0] O_MOVE_SPEED,
    output logic [15:0] O_ACCEL,
    output logic [15:0] O_DECEL,
    output logic [15:0] O_TORQUE_LIMIT,
    output logic [31:0] O_TARGET_POS,
    output logic [3:0] O_AUX,
    output logic O_DOG_HOME_GO,
    output logic O_SOFT_LIMIT_EN,
    // home state
    output logic O_HOME_DONE_FLAG,
    output logic O_HOME_NOT_FOUND,
    output logic [31:0] O_HOME_DATA
);
    if (P_CYC_PER_MS < 1 || P_CYC_PER_MS > 65536) begin : g_bad_cyc
        $error("P_CYC_PER_MS out of range 1..65536");
    end

    localparam logic [15:0] PRE_MAX = 16'(P_CYC_PER_MS - 1);

    typedef struct packed {
        hrsp_state_e state;
        logic [NUM_PINS-1:0] sync1;
        logic [NUM_PINS-1:0] sync2;
        logic st_prev;
        logic srv_prev;
        logic [15:0] pre;
        logic [15:0] ms;
        logic seen_dog;
        logic [CTRL_W-1:0] ctrl;
        logic [15:0] home_spd;
        logic [15:0] stop_time;
        logic [15:0] stop_trq;
        logic [31:0] home_data;
        logic done;
        logic alarm;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic [6:0] frc;
        hrsp_entry_s [NUM_TABLES-1:0] tbl;
        logic mv;
        logic dir;
        logic dog_go;
        logic reply;
        logic [15:0] spd;
        logic [15:0] acc;
        logic [15:0] dec;
        logic [15:0] trq;
        logic [3:0] aux;
        logic [31:0] tgt;
        logic [31:0] rdata;
    } hrsp_regs_s;

    hrsp_regs_s r;
    hrsp_regs_s n;
    logic [NUM_PINS-1:0] pins_raw;
    logic [2:0] meth;
    logic home_dir;
    logic link_en;
    logic md;
    logic [3:0] sel;
    logic fwd_go;
    logic rev_go;
    logic start;
    logic srv;
    logic srv_rise;
    logic dog;
    logic lim_home;
    logic lim_away;
    logic home_mode;
    logic accept;
    logic [3:0] widx;
    logic [3:0] tidx;
    logic done_ev;
    logic alarm_ev;
    logic posn_ev;
    logic mapped;
    logic [31:0] rmux;

    // pin bundle and configuration fields
    assign pins_raw = {I_LIMIT_REV, I_LIMIT_FWD, I_DOG, I_SERVO_ON, I_REVERSE_START,
                       I_FORWARD_START, I_TABLE_SELECT_BIT1, I_TABLE_SELECT_BIT0,
                       I_AUTO_MANUAL_SELECT};
    assign meth = r.ctrl[CTRL_METH_LSB +: 3];
    assign home_dir = r.ctrl[CTRL_DIR];
    assign link_en = r.ctrl[CTRL_LINK_EN];

    // effective operator inputs: serial forced bits replace pins when the link drives
    assign md = link_en ? r.frc[FRC_MD] : r.sync2[PIN_MD];
    assign sel = link_en ? r.frc[3:0] : {2'b00, r.sync2[PIN_SEL1], r.sync2[PIN_SEL0]};
    assign fwd_go = link_en ? r.frc[FRC_FWD] : r.sync2[PIN_FWD];
    assign rev_go = link_en ? r.frc[FRC_REV] : r.sync2[PIN_REV];
    assign start = (fwd_go | rev_go) & ~r.st_prev;
    assign srv = r.sync2[PIN_SRV];
    assign srv_rise = srv & ~r.srv_prev;
    assign dog = r.sync2[PIN_DOG];
    // limit in the home-ward direction and the one behind it
    assign lim_home = home_dir ? r.sync2[PIN_LSN] : r.sync2[PIN_LSP];
    assign lim_away = home_dir ? r.sync2[PIN_LSP] : r.sync2[PIN_LSN];
    assign home_mode = md & (sel == 4'h0);
    // only frames on the chosen port and for our station count
    assign accept = I_FRM_VALID & link_en & (I_FRM_PORT == r.ctrl[CTRL_PORT])
                    & (I_FRM_STATION == r.ctrl[CTRL_STN_LSB +: 5]);
    assign widx = 4'(I_FRM_DNO - 8'h01);
    assign tidx = 4'(sel - 4'h1);

    // register decode and read mux
    always_comb
    begin
        mapped = 1'b1;
        rmux = REG_RST;
        unique case (I_PADDR)
            OFS_CTRL: rmux = 32'(r.ctrl);
            OFS_HOME_SPEED: rmux = 32'(r.home_spd);
            OFS_STOP_TIME: rmux = 32'(r.stop_time);
            OFS_STOP_TORQUE: rmux = 32'(r.stop_trq);
            OFS_HOME_DATA: rmux = r.home_data;
            OFS_STATUS:
            begin
                rmux[STAT_DONE] = r.done;
                rmux[STAT_ALARM] = r.alarm;
                rmux[STAT_MOVE] = r.mv;
                rmux[STAT_STATE_LSB +: 3] = r.state;
            end
            OFS_IRQ_STAT: rmux = 32'(r.irq_st);
            OFS_IRQ_MASK: rmux = 32'(r.irq_mask);
            default: mapped = 1'b0;
        endcase
    end

    // next state of the whole block
    always_comb
    begin
        n = r;
        done_ev = 1'b0;
        alarm_ev = 1'b0;
        posn_ev = 1'b0;
        n.sync1 = pins_raw;
        n.sync2 = r.sync1;
        n.st_prev = fwd_go | rev_go;
        n.srv_prev = srv;
        n.dog_go = 1'b0;
        n.reply = 1'b0;
        // apb: read data captured in setup, writes in access phase
        if (I_PSEL && !I_PENABLE)
            n.rdata = rmux;
        if (I_PSEL && I_PENABLE && I_PWRITE)
        begin
            unique case (I_PADDR)
                OFS_CTRL: n.ctrl = I_PWDATA[CTRL_W-1:0];
                OFS_HOME_SPEED: n.home_spd = I_PWDATA[15:0];
                OFS_STOP_TIME: n.stop_time = I_PWDATA[15:0];
                OFS_STOP_TORQUE: n.stop_trq = I_PWDATA[15:0];
                OFS_HOME_DATA: n.home_data = I_PWDATA;
                OFS_IRQ_STAT: n.irq_st = r.irq_st & ~I_PWDATA[IRQ_W-1:0];
                OFS_IRQ_MASK: n.irq_mask = I_PWDATA[IRQ_W-1:0];
                default: ;
            endcase
        end
        // serial commands
        if (accept)
        begin
            n.reply = 1'b1;
            if (I_FRM_CMD == CMD_FORCE && I_FRM_DNO == DNO_FORCE)
                n.frc = I_FRM_DATA[6:0];
            else if (I_FRM_DNO >= 8'h01 && I_FRM_DNO <= 8'(NUM_TABLES))
            begin
                unique case (I_FRM_CMD)
                    CMD_POS: n.tbl[widx].pos = I_FRM_DATA;
                    CMD_SPD: n.tbl[widx].spd = I_FRM_DATA[15:0];
                    CMD_ACC: n.tbl[widx].acc = I_FRM_DATA[15:0];
                    CMD_DEC: n.tbl[widx].dec = I_FRM_DATA[15:0];
                    CMD_AUX: n.tbl[widx].aux = I_FRM_DATA[3:0];
                    default: ;
                endcase
            end
        end
        // sequencer
        unique case (r.state)
            ST_IDLE:
            begin
                if (start && srv && home_mode)
                begin
                    n.done = 1'b0;
                    n.alarm = 1'b0;
                    n.spd = r.home_spd;
                    n.acc = r.tbl[0].acc;
                    n.dir = home_dir;
                    n.seen_dog = 1'b0;
                    if (meth == METH_DATA)
                        done_ev = 1'b1;
                    else if (meth == METH_STOP)
                    begin
                        n.state = ST_STOP_SEEK;
                        n.mv = 1'b1;
                        n.trq = r.stop_trq;
                    end
                    else if (meth == METH_DOG || meth == METH_COUNT)
                    begin
                        n.state = ST_AUTO_SEEK;
                        n.mv = 1'b1;
                    end
                end
                else if (start && srv && md)
                begin
                    // positioning from the selected entry
                    n.state = ST_POSN;
                    n.mv = 1'b1;
                    n.dir = rev_go & ~fwd_go;
                    n.tgt = r.tbl[tidx].pos;
                    n.spd = r.tbl[tidx].spd;
                    n.acc = r.tbl[tidx].acc;
                    n.dec = r.tbl[tidx].dec;
                    n.aux = r.tbl[tidx].aux;
                end
            end
            ST_STOP_SEEK:
            begin
                if (I_TORQUE_AT_LIMIT)
                begin
                    n.state = ST_STOP_DWELL;
                    n.pre = 16'h0000;
                    n.ms = 16'h0000;
                end
            end
            ST_STOP_DWELL:
            begin
                if (r.ms == r.stop_time)
                begin
                    n.state = ST_IDLE;
                    n.mv = 1'b0;
                    n.trq = TRQ_FULL;
                    done_ev = 1'b1;
                end
                else if (r.pre == PRE_MAX)
                begin
                    n.pre = 16'h0000;
                    n.ms = r.ms + 16'h0001;
                end
                else
                    n.pre = r.pre + 16'h0001;
            end
            ST_AUTO_SEEK:
            begin
                if (dog)
                begin
                    n.state = ST_IDLE; // dog ahead: normal search takes over
                    n.mv = 1'b0;
                    n.dog_go = 1'b1;
                end
                else if (lim_home)
                begin
                    n.state = ST_AUTO_BACK;
                    n.dir = ~r.dir;
                end
            end
            ST_AUTO_BACK:
            begin
                if (dog)
                    n.seen_dog = 1'b1;
                if (r.seen_dog && !dog)
                begin
                    n.state = ST_IDLE;
                    n.mv = 1'b0;
                    n.dog_go = 1'b1;
                end
                else if (lim_away && !r.seen_dog && !dog)
                begin
                    n.state = ST_IDLE;
                    n.mv = 1'b0;
                    alarm_ev = 1'b1;
                end
            end
            ST_POSN:
            begin
                if (I_IN_POSITION)
                begin
                    n.state = ST_IDLE;
                    n.mv = 1'b0;
                    posn_ev = 1'b1;
                end
            end
        endcase
        // servo off aborts any motion
        if (!srv && r.state != ST_IDLE)
        begin
            n.state = ST_IDLE;
            n.mv = 1'b0;
            n.trq = TRQ_FULL;
        end
        // servo-on position becomes home at once
        if (meth == METH_IGNORE && srv_rise)
            done_ev = 1'b1;
        // completion capture, events win over software clears
        if (done_ev)
        begin
            n.home_data = I_POSITION;
            n.done = 1'b1;
        end
        if (alarm_ev)
            n.alarm = 1'b1;
        n.irq_st = n.irq_st | {posn_ev, alarm_ev, done_ev};
    end

    // state register
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SYS_RST)
        begin
            r <= '0;
            r.trq <= TRQ_FULL;
        end
        else
            r <= n;
    end

    // outputs
    assign O_PRDATA = r.rdata;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
    assign O_IRQ = |(r.irq_st & r.irq_mask);
    assign O_REPLY_VALID = r.reply;
    assign O_MOVE_ACTIVE = r.mv;
    assign O_MOVE_DIR = r.dir;
    assign O_MOVE_SPEED = r.spd;
    assign O_ACCEL = r.acc;
    assign O_DECEL = r.dec;
    assign O_TORQUE_LIMIT = r.trq;
    assign O_TARGET_POS = r.tgt;
    assign O_AUX = r.aux;
    assign O_DOG_HOME_GO = r.dog_go;
    assign O_SOFT_LIMIT_EN = r.ctrl[CTRL_SOFTLIM] & (meth > METH_COUNT);
    assign O_HOME_DONE_FLAG = r.done;
    assign O_HOME_NOT_FOUND = r.alarm;
    assign O_HOME_DATA = r.home_data;

    // checks
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);

    sequence s_contact;
        r.state == ST_STOP_SEEK && I_TORQUE_AT_LIMIT && srv;
    endsequence
    sequence s_dwell_end;
        r.state == ST_STOP_DWELL && r.ms == r.stop_time && srv;
    endsequence

    a_data_capture: assert property (r.state == ST_IDLE && start && srv && home_mode
        && meth == METH_DATA |=> r.done && r.home_data == $past(I_POSITION))
        else $error("data-setting home not captured");
    a_stop_drive: assert property (r.state == ST_STOP_SEEK |-> O_MOVE_ACTIVE
        && O_MOVE_SPEED == r.home_spd && O_ACCEL == r.tbl[0].acc)
        else $error("stopper seek speed or accel wrong");
    a_stop_torque: assert property (r.state inside {ST_STOP_SEEK, ST_STOP_DWELL}
        |-> O_TORQUE_LIMIT == r.stop_trq)
        else $error("stopper torque limit not applied");
    a_stop_dwell: assert property (s_contact |=> r.state == ST_STOP_DWELL && !r.done)
        else $error("stopper contact not followed by dwell");
    a_stop_done: assert property (s_dwell_end |=> r.done && !r.mv
        && r.home_data == $past(I_POSITION) && O_TORQUE_LIMIT == TRQ_FULL)
        else $error("stopper dwell end missed");
    a_ignore_home: assert property (meth == METH_IGNORE && srv_rise |=> r.done
        && r.home_data == $past(I_POSITION))
        else $error("servo-on home not taken");
    a_auto_reverse: assert property (r.state == ST_AUTO_SEEK && srv && !dog && lim_home
        |=> r.state == ST_AUTO_BACK && r.dir != $past(r.dir))
        else $error("no reversal at limit");
    a_home_alarm: assert property (r.state == ST_AUTO_BACK && srv && !r.seen_dog
        && !dog && lim_away |=> r.alarm && !r.mv ##1 O_HOME_NOT_FOUND)
        else $error("home-not-found alarm missing");
    a_soft_limit: assert property (meth <= METH_COUNT |-> !O_SOFT_LIMIT_EN)
        else $error("soft limit active during auto return");
    a_foreign_drop: assert property (I_FRM_VALID && (I_FRM_STATION
        != r.ctrl[CTRL_STN_LSB +: 5] || I_FRM_PORT != r.ctrl[CTRL_PORT]) |=> !O_REPLY_VALID)
        else $error("answered a foreign frame");
    a_table_write: assert property (accept && I_FRM_CMD == CMD_SPD
        && I_FRM_DNO == 8'h01 |=> r.tbl[0].spd == $past(I_FRM_DATA[15:0]))
        else $error("table speed write lost");
    a_posn_start: assert property (r.state == ST_IDLE && start && srv && md
        && sel != 4'h0 |=> r.state == ST_POSN && O_MOVE_ACTIVE)
        else $error("positioning did not start");
endmodule : hrsp_top
`default_nettype wire

// *** tb/hrsp_host_model.sv ***
// host controller model that presents decoded serial frames to the block
`timescale 1ns/1ns
`default_nettype none
module hrsp_host_model (
    // clock and frame request
    input wire logic i_clk,
    input wire logic i_send,
    input wire logic i_port,
    input wire logic [4:0] i_stn,
    input wire logic [7:0] i_cmd,
    input wire logic [7:0] i_dno,
    input wire logic [31:0] i_data,
    // frame towards the block
    output logic o_valid,
    output logic [53:0] o_frame
);
    // one frame per request; fields toggle between frames so stale data never looks valid
    always_ff @(posedge i_clk)
    begin
        o_valid <= i_send;
        if (i_send)
            o_frame <= {i_port, i_stn, i_cmd, i_dno, i_data};
        else
            o_frame <= ~o_frame;
    end
endmodule : hrsp_host_model
`default_nettype wire

// *** tb/hrsp_top_tb_top.sv ***
// self-checking bench for the home-return and serial positioning block
`timescale 1ns/1ns
`default_nettype none
module hrsp_top_tb_top
    import hrsp_pkg::*;
;
    logic clk, rst, psel, pen, pwr, rerr, md, fwd, srv, lf, lr, tq, inp, send, fp, reply, fv;
    logic mact, mdir, slen, done, nf, irq, pready, pslverr, dg, dgo;
    logic [11:0] paddr;
    logic [4:0] fst;
    logic [7:0] fc, fd;
    logic [15:0] mspd, acc, dec, trq;
    logic [3:0] aux;
    logic [53:0] frm;
    logic [31:0] pwdata, prdata, rdv, pos, fdat, tgt, hdata;
    int error_cnt = 0, samples_checked = 0, cyc = 0, n;
    logic [7:0] cmds [5] = '{CMD_POS, CMD_SPD, CMD_ACC, CMD_DEC, CMD_AUX};
    logic [31:0] vals [5] = '{32'h00ab_cdef, 32'h0000_0123, 32'h0000_0045, 32'h0000_0067, 32'h9};

    hrsp_top #(.P_CYC_PER_MS(4)) u_hrsp_top (
        .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_IRQ(irq), .I_AUTO_MANUAL_SELECT(md), .I_TABLE_SELECT_BIT0(1'b0),
        .I_TABLE_SELECT_BIT1(1'b0), .I_FORWARD_START(fwd), .I_REVERSE_START(1'b0),
        .I_SERVO_ON(srv), .I_DOG(dg), .I_LIMIT_FWD(lf), .I_LIMIT_REV(lr), .I_POSITION(pos),
        .I_TORQUE_AT_LIMIT(tq), .I_IN_POSITION(inp), .I_FRM_VALID(fv), .I_FRM_PORT(frm[53]),
        .I_FRM_STATION(frm[52:48]), .I_FRM_CMD(frm[47:40]), .I_FRM_DNO(frm[39:32]),
        .I_FRM_DATA(frm[31:0]), .O_REPLY_VALID(reply), .O_MOVE_ACTIVE(mact), .O_MOVE_DIR(mdir),
        .O_MOVE_SPEED(mspd), .O_ACCEL(acc), .O_DECEL(dec), .O_TORQUE_LIMIT(trq),
        .O_TARGET_POS(tgt), .O_AUX(aux), .O_DOG_HOME_GO(dgo), .O_SOFT_LIMIT_EN(slen),
        .O_HOME_DONE_FLAG(done), .O_HOME_NOT_FOUND(nf), .O_HOME_DATA(hdata)
    );
    hrsp_host_model u_hrsp_host_model (
        .i_clk(clk), .i_send(send), .i_port(fp), .i_stn(fst), .i_cmd(fc), .i_dno(fd),
        .i_data(fdat), .o_valid(fv), .o_frame(frm)
    );

    // free-running clock and cycle ceiling
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // apb transfer: setup, access held until pready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk("prdata", rdv, exp);
        chk("pslverr", 32'(rerr), 32'(err));
    endtask : rd
    task automatic frame(input logic p, input logic [4:0] s, input logic [7:0] c,
        input logic [7:0] dn, input logic [31:0] d, input logic er);
        @(posedge clk);
        send <= 1'b1;
        fp <= p;
        fst <= s;
        fc <= c;
        fd <= dn;
        fdat <= d;
        @(posedge clk);
        send <= 1'b0;
        tick(1);
        chk("reply", 32'(reply), 32'(er));
    endtask : frame
    task automatic pin_start();
        @(posedge clk);
        fwd <= 1'b1;
        tick(6);
        @(posedge clk);
        fwd <= 1'b0;
        tick(1);
    endtask : pin_start

    task automatic t_serial();
        apb(1'b1, OFS_CTRL, 32'h340);
        frame(1'b0, 5'h03, CMD_ACC, 8'h01, 32'h77, 1'b1);
        for (int i = 0; i < 5; i++)
            frame(1'b0, 5'h03, cmds[i], 8'h02, vals[i], 1'b1);
        frame(1'b0, 5'h04, CMD_FORCE, DNO_FORCE, 32'h12, 1'b0);
        frame(1'b1, 5'h03, CMD_FORCE, DNO_FORCE, 32'h12, 1'b0);
        tick(3);
        chk("idle", 32'(mact), 32'h0);
        frame(1'b0, 5'h03, CMD_FORCE, DNO_FORCE, 32'h52, 1'b1);
        tick(2);
        chk("move", 32'(mact), 32'h1);
        chk("target", tgt, vals[0]);
        chk("speed", 32'(mspd), vals[1]);
        chk("accel", 32'(acc), vals[2]);
        chk("decel", 32'(dec), vals[3]);
        chk("aux", 32'(aux), vals[4]);
        frame(1'b0, 5'h03, CMD_FORCE, DNO_FORCE, 32'h42, 1'b1);
        @(posedge clk);
        inp <= 1'b1;
        @(posedge clk);
        inp <= 1'b0;
        tick(2);
        chk("arrived", 32'(mact), 32'h0);
        rd(OFS_IRQ_STAT, 32'h4, 1'b0);
        apb(1'b1, OFS_IRQ_STAT, 32'h4);
        rd(12'h020, 32'h0, 1'b1);
        $display("end serial test");
    endtask : t_serial

    task automatic t_data();
        apb(1'b1, OFS_CTRL, 32'h12);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        md <= 1'b1;
        pos <= 32'h0000_1234;
        pin_start();
        chk("done", 32'(done), 32'h1);
        chk("home", hdata, 32'h0000_1234);
        chk("irq", 32'(irq), 32'h1);
        chk("softlim", 32'(slen), 32'h1);
        rd(OFS_HOME_DATA, 32'h0000_1234, 1'b0);
        apb(1'b1, OFS_IRQ_STAT, 32'h1);
        tick(1);
        chk("irq clr", 32'(irq), 32'h0);
        $display("end data test");
    endtask : t_data

    task automatic t_stop();
        apb(1'b1, OFS_HOME_SPEED, 32'h50);
        apb(1'b1, OFS_STOP_TIME, 32'h2);
        apb(1'b1, OFS_STOP_TORQUE, 32'h300);
        apb(1'b1, OFS_CTRL, 32'h3);
        pin_start();
        chk("cleared", 32'(done), 32'h0);
        chk("speed", 32'(mspd), 32'h50);
        chk("torque", 32'(trq), 32'h300);
        chk("accel", 32'(acc), 32'h77);
        @(posedge clk);
        pos <= 32'h0000_5555;
        tq <= 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
        chk("dwell", 32'(n >= 8 && n <= 16), 32'h1);
        chk("torque off", 32'(trq), 32'hffff);
        chk("home", hdata, 32'h0000_5555);
        @(posedge clk);
        tq <= 1'b0;
        $display("end stopper test");
    endtask : t_stop

    task automatic t_auto();
        apb(1'b1, OFS_CTRL, 32'h4);
        srv <= 1'b0;
        tick(4);
        @(posedge clk);
        pos <= 32'h0000_0777;
        srv <= 1'b1;
        tick(5);
        chk("servo home", hdata, 32'h0000_0777);
        apb(1'b1, OFS_CTRL, 32'h10);
        tick(1);
        chk("softlim", 32'(slen), 32'h0);
        pin_start();
        chk("seek", 32'({mact, mdir}), 32'h2);
        @(posedge clk);
        lf <= 1'b1;
        tick(4);
        chk("reverse", 32'({mact, mdir}), 32'h3);
        @(posedge clk);
        lf <= 1'b0;
        lr <= 1'b1;
        tick(4);
        chk("not found", 32'({mact, nf}), 32'h1);
        @(posedge clk);
        lr <= 1'b0;
        rd(OFS_IRQ_STAT, 32'h3, 1'b0);
        // second pass: dog passed after the reversal, then hand-over pulse
        pin_start();
        @(posedge clk);
        lf <= 1'b1;
        tick(4);
        @(posedge clk);
        lf <= 1'b0;
        dg <= 1'b1;
        tick(4);
        @(posedge clk);
        dg <= 1'b0;
        tick(3);
        chk("dog hand-over", 32'({dgo, mact, nf}), 32'h4);
        $display("end auto return test");
    endtask : t_auto

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    // reset, then the scenarios in order
    initial
    begin
        {rst, psel, pen, pwr, md, fwd, lf, lr, tq, inp, send, fp} = 12'h800;
        srv = 1'b1;
        dg = 1'b0;
        {paddr, pwdata, pos, fdat, fst, fc, fd} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CTRL, 32'h0, 1'b0);
        t_serial();
        t_data();
        t_stop();
        t_auto();
        wrap_up();
    end
endmodule : hrsp_top_tb_top
`default_nettype wire
